// >>> common/vctc_cfg.svh
// Offsets, field positions, reset values and timing counts of the capture controller.
`ifndef VCTC_CFG_SVH
`define VCTC_CFG_SVH
`define VCTC_OFF_GCMD 8'h00
`define VCTC_OFF_RCTL 8'h04
`define VCTC_OFF_RPRD 8'h08
`define VCTC_OFF_AVG 8'h0C
`define VCTC_OFF_MISC 8'h10
`define VCTC_OFF_NULL 8'h14
`define VCTC_OFF_DIAG 8'h18
`define VCTC_OFF_STAT 8'h1C
`define VCTC_GCMD_START 11
`define VCTC_GCMD_OFFSET_NULL_REG 0
`define VCTC_RCTL_TMO 15
`define VCTC_RCTL_SR 8
`define VCTC_MISC_SYNC 12
`define VCTC_DIAG_ESC 4
`define VCTC_ESCAPE 16'h00E8
`define VCTC_SPI_GCMD_LO 7'h3E
`define VCTC_SPI_GCMD_HI 7'h3F
`define VCTC_RST_REG 16'h0000
`define VCTC_CLK_HZ 250000000
`define VCTC_BASE_SPS 220000
`define VCTC_BASE_DIV (`VCTC_CLK_HZ / `VCTC_BASE_SPS)
`define VCTC_TMO_MS 30
`define VCTC_TMO_CYC (`VCTC_CLK_HZ / 1000 * `VCTC_TMO_MS)
`define VCTC_PRD_TICK_CYC (`VCTC_CLK_HZ / 1000)
`define VCTC_REC_LEN 4096
`define VCTC_POWERUP_CYC 1000
`define VCTC_PROC_CYC 64
`endif

// >>> common/vctc_pkg.sv
// Types shared by the capture controller.
package vctc_pkg;
	typedef enum logic [5:0] {
		VCTC_POWERUP = 6'h01,
		VCTC_IDLE = 6'h02,
		VCTC_CAPT = 6'h04,
		VCTC_PROC = 6'h08,
		VCTC_WAIT = 6'h10,
		VCTC_STREAM = 6'h20
	} vctc_state_t;
	typedef enum logic [1:0] {
		VCTC_M_TIME = 2'h0,
		VCTC_M_MSPEC = 2'h1,
		VCTC_M_ASPEC = 2'h2,
		VCTC_M_RAW = 2'h3
	} vctc_mode_t;
endpackage : vctc_pkg

// >>> src/vctc_top.sv
// Capture and trigger controller of the vibration module: serial link, APB registers, sequencer.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "vctc_cfg.svh"
module vctc_top import vctc_pkg::*; #(
	parameter int POWERUP_CYC = `VCTC_POWERUP_CYC,
	parameter int TMO_CYC = `VCTC_TMO_CYC,
	parameter int PRD_TICK_CYC = `VCTC_PRD_TICK_CYC,
	parameter int PROC_CYC = `VCTC_PROC_CYC,
	parameter int REC_LEN = `VCTC_REC_LEN
) (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic NRST,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Host serial link and sync/stop pin.
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	input wire logic SYNC_STOP,
	output logic BUSY,
	// Offset estimate from the sensor front end.
	input wire logic [15:0] OFFSET_EST,
	// Datapath control.
	output logic SAMPLE_STROBE,
	output logic CAPTURING,
	output logic STREAMING,
	output logic FILTER_EN,
	output logic FFT_EN,
	output logic DATA_DISCARD,
	output logic [1:0] RATE_SEL
);
	vctc_state_t state_reg, state_next;
	vctc_mode_t mode;
	logic [15:0] gcmd_reg, rctl_reg, rprd_reg, avg_reg, misc_reg, null_reg, diag_reg;
	logic [15:0] sh_reg, cmd_val, base_reg, dec_reg, samp_reg, prd_reg;
	logic [31:0] cnt_reg, tick_reg, tmo_reg;
	logic [7:0] lo_reg;
	logic [3:0] pin_in, lvl_reg, lvl_d_reg, bit_reg, avg_sel;
	logic [2:0] pin_sh [4];
	logic [1:0] opt_reg, opt_next;
	logic sclk_rise, sync_rise, cs_high, sclk_edge, word_vld_reg, lo_ok_reg, spi_cmd;
	logic apb_wr, apb_cmd, cmd_ev, esc_ev, start_ev, offset_null_reg_ev, start_trig, opt_found;
	logic base_tick, samp_tick, tmo_hit, tmo_arm_reg, offset_null_reg_reg;

	// Mode field, and the raw pins in the bit order of the synchroniser.
	assign mode = vctc_mode_t'(rctl_reg[1:0]);
	assign pin_in = {SYNC_STOP, DIN, CS_N, SCLK};

	// Pins from the host pass three flops; a level counts once the second and third agree.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < 4; i++) begin
				pin_sh[i] <= (i < 2) ? 3'h7 : 3'h0;
			end
			lvl_reg <= 4'h3; // Idle levels, so that no false edge follows reset.
			lvl_d_reg <= 4'h3;
		end else begin
			for (int i = 0; i < 4; i++) begin
				pin_sh[i] <= {pin_sh[i][1:0], pin_in[i]};
				if (pin_sh[i][1] == pin_sh[i][2]) begin
					lvl_reg[i] <= pin_sh[i][2];
				end
			end
			lvl_d_reg <= lvl_reg;
		end
	end
	assign sclk_rise = lvl_reg[0] & ~lvl_d_reg[0];
	assign sclk_edge = lvl_reg[0] ^ lvl_d_reg[0];
	assign cs_high = lvl_reg[1];
	assign sync_rise = lvl_reg[3] & ~lvl_d_reg[3] & misc_reg[`VCTC_MISC_SYNC];

	// Serial shift register; a word is sixteen rising clocks inside one select.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			sh_reg <= 16'h0000;
			bit_reg <= 4'h0;
			word_vld_reg <= 1'b0;
		end else begin
			word_vld_reg <= 1'b0;
			if (cs_high) begin
				bit_reg <= 4'h0;
			end else if (sclk_rise) begin
				sh_reg <= {sh_reg[14:0], lvl_reg[2]};
				bit_reg <= bit_reg + 4'h1;
				word_vld_reg <= (bit_reg == 4'hF);
			end
		end
	end

	// Byte commands pair low then high into one global command value.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			lo_reg <= 8'h00;
			lo_ok_reg <= 1'b0;
		end else if (word_vld_reg && sh_reg[15] && state_reg != VCTC_STREAM) begin
			if (sh_reg[14:8] == `VCTC_SPI_GCMD_LO) begin
				lo_reg <= sh_reg[7:0];
				lo_ok_reg <= 1'b1;
			end else if (sh_reg[14:8] == `VCTC_SPI_GCMD_HI) begin
				lo_ok_reg <= 1'b0;
			end
		end
	end
	assign spi_cmd = word_vld_reg && sh_reg[15] && state_reg != VCTC_STREAM && lo_ok_reg
		&& sh_reg[14:8] == `VCTC_SPI_GCMD_HI;
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign apb_cmd = apb_wr && PADDR == `VCTC_OFF_GCMD && state_reg != VCTC_STREAM;
	assign cmd_ev = spi_cmd | apb_cmd;
	assign cmd_val = spi_cmd ? {sh_reg[7:0], lo_reg} : PWDATA[15:0];

	// Escape is honoured only in capture, processing and wait; other commands only while busy is high.
	assign esc_ev = cmd_ev && cmd_val == `VCTC_ESCAPE
		&& (state_reg == VCTC_CAPT || state_reg == VCTC_PROC || state_reg == VCTC_WAIT);
	assign start_ev = cmd_ev && cmd_val != `VCTC_ESCAPE && cmd_val[`VCTC_GCMD_START]
		&& (state_reg == VCTC_IDLE || state_reg == VCTC_WAIT);
	assign offset_null_reg_ev = cmd_ev && cmd_val != `VCTC_ESCAPE && cmd_val[`VCTC_GCMD_OFFSET_NULL_REG]
		&& state_reg == VCTC_IDLE;
	assign start_trig = start_ev | sync_rise;

	// First enabled rate option after the current one, spectrum cycling only.
	always_comb begin
		opt_next = 2'h0;
		opt_found = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			if (rctl_reg[`VCTC_RCTL_SR + i] && (state_reg != VCTC_PROC || 2'(i) > opt_reg)) begin
				opt_next = 2'(i);
				opt_found = 1'b1;
			end
		end
	end
	// Time capture runs undecimated except during autonull; autonull and the other modes use the option's average count.
	assign avg_sel = (mode == VCTC_M_TIME && !offset_null_reg_reg) ? 4'h0 : avg_reg[4*opt_reg +: 4];

	// Sequencer.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			VCTC_POWERUP: if (cnt_reg == 32'(POWERUP_CYC - 1)) state_next = VCTC_IDLE;
			VCTC_IDLE: begin
				if (offset_null_reg_ev) begin
					state_next = VCTC_CAPT;
				end else if (start_trig) begin
					state_next = (mode == VCTC_M_RAW) ? VCTC_STREAM : VCTC_CAPT;
				end
			end
			VCTC_CAPT: begin
				if (esc_ev) state_next = VCTC_IDLE;
				else if (samp_reg == 16'(REC_LEN)) state_next = VCTC_PROC;
			end
			VCTC_PROC: begin
				if (esc_ev) begin
					state_next = VCTC_IDLE;
				end else if (cnt_reg == 32'(PROC_CYC - 1)) begin
					if (offset_null_reg_reg || mode != VCTC_M_ASPEC) state_next = VCTC_IDLE;
					else state_next = opt_found ? VCTC_CAPT : VCTC_WAIT;
				end
			end
			VCTC_WAIT: begin
				if (esc_ev || start_ev) state_next = VCTC_IDLE;
				else if (prd_reg >= rprd_reg) state_next = VCTC_CAPT;
			end
			VCTC_STREAM: if (sync_rise || tmo_hit) state_next = VCTC_IDLE;
			default: state_next = VCTC_POWERUP;
		endcase
	end

	// State, option and shared cycle counter.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= VCTC_POWERUP;
			cnt_reg <= 32'h0;
			opt_reg <= 2'h0;
			offset_null_reg_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= (state_next != state_reg) ? 32'h0 : cnt_reg + 32'h1;
			if (state_reg == VCTC_IDLE && offset_null_reg_ev) begin
				offset_null_reg_reg <= 1'b1;
				opt_reg <= 2'h3;
			end else if (state_next == VCTC_CAPT && state_reg != VCTC_CAPT) begin
				opt_reg <= opt_next;
			end else if (state_next == VCTC_IDLE) begin
				offset_null_reg_reg <= 1'b0;
			end
		end
	end

	// Base 220 kHz tick and decimation by two to the average count.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			base_reg <= 16'h0;
			dec_reg <= 16'h0;
			samp_reg <= 16'h0;
		end else if (state_reg != VCTC_CAPT && state_reg != VCTC_STREAM) begin
			base_reg <= 16'h0;
			dec_reg <= 16'h0;
			samp_reg <= 16'h0;
		end else begin
			base_reg <= base_tick ? 16'h0 : base_reg + 16'h1;
			if (base_tick) begin
				dec_reg <= samp_tick ? 16'h0 : dec_reg + 16'h1;
			end
			if (samp_tick && state_reg == VCTC_CAPT) begin
				samp_reg <= samp_reg + 16'h1;
			end
		end
	end
	assign base_tick = base_reg == 16'(`VCTC_BASE_DIV - 1);
	assign samp_tick = base_tick && (state_reg == VCTC_STREAM
		|| dec_reg == (16'h1 << avg_sel) - 16'h1);

	// Record period counter in millisecond ticks, restarted at each capture start not entered from processing.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tick_reg <= 32'h0;
			prd_reg <= 16'h0;
		end else if (state_next == VCTC_CAPT && state_reg != VCTC_CAPT
			&& state_reg != VCTC_PROC) begin
			tick_reg <= 32'h0;
			prd_reg <= 16'h0;
		end else if (tick_reg == 32'(PRD_TICK_CYC - 1)) begin
			tick_reg <= 32'h0;
			prd_reg <= (prd_reg == 16'hFFFF) ? prd_reg : prd_reg + 16'h1;
		end else begin
			tick_reg <= tick_reg + 32'h1;
		end
	end

	// Stream timeout counts only quiet cycles with select low; arming is latched at start.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tmo_reg <= 32'h0;
			tmo_arm_reg <= 1'b0;
		end else begin
			if (state_reg == VCTC_IDLE) tmo_arm_reg <= rctl_reg[`VCTC_RCTL_TMO];
			if (state_reg != VCTC_STREAM || cs_high || sclk_edge) tmo_reg <= 32'h0;
			else tmo_reg <= tmo_reg + 32'h1;
		end
	end
	assign tmo_hit = tmo_arm_reg && tmo_reg == 32'(TMO_CYC - 1);

	// Registers reached over APB; the escape flag is write-one-to-clear, and a set wins.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			gcmd_reg <= `VCTC_RST_REG;
			rctl_reg <= `VCTC_RST_REG;
			rprd_reg <= `VCTC_RST_REG;
			avg_reg <= `VCTC_RST_REG;
			misc_reg <= `VCTC_RST_REG;
			null_reg <= `VCTC_RST_REG;
			diag_reg <= `VCTC_RST_REG;
		end else begin
			if (cmd_ev) gcmd_reg <= cmd_val;
			if (apb_wr && state_reg == VCTC_IDLE) begin
				case (PADDR)
					`VCTC_OFF_RCTL: rctl_reg <= PWDATA[15:0];
					`VCTC_OFF_RPRD: rprd_reg <= PWDATA[15:0];
					`VCTC_OFF_AVG: avg_reg <= PWDATA[15:0];
					`VCTC_OFF_MISC: misc_reg <= PWDATA[15:0];
					default: ;
				endcase
			end
			if (state_reg == VCTC_PROC && state_next == VCTC_IDLE && offset_null_reg_reg && !esc_ev) begin
				null_reg <= OFFSET_EST;
			end else if (apb_wr && PADDR == `VCTC_OFF_NULL && state_reg == VCTC_IDLE) begin
				null_reg <= PWDATA[15:0];
			end
			if (esc_ev) diag_reg[`VCTC_DIAG_ESC] <= 1'b1;
			else if (apb_wr && PADDR == `VCTC_OFF_DIAG && PWDATA[`VCTC_DIAG_ESC]) begin
				diag_reg[`VCTC_DIAG_ESC] <= 1'b0;
			end
		end
	end

	// APB read mux; zero-wait answer, error on unmapped offsets.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
			PREADY <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0;
			if (PSEL && !PENABLE) begin
				case (PADDR)
					`VCTC_OFF_GCMD: PRDATA <= {16'h0, gcmd_reg};
					`VCTC_OFF_RCTL: PRDATA <= {16'h0, rctl_reg};
					`VCTC_OFF_RPRD: PRDATA <= {16'h0, rprd_reg};
					`VCTC_OFF_AVG: PRDATA <= {16'h0, avg_reg};
					`VCTC_OFF_MISC: PRDATA <= {16'h0, misc_reg};
					`VCTC_OFF_NULL: PRDATA <= {16'h0, null_reg};
					`VCTC_OFF_DIAG: PRDATA <= {16'h0, diag_reg};
					`VCTC_OFF_STAT: PRDATA <= {24'h0, opt_reg, state_reg};
					default: PSLVERR <= 1'b1;
				endcase
			end
		end
	end

	// State outputs follow the next state so they line up with the state register; strobe, discard and rate are registered copies.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			BUSY <= 1'b0;
			CAPTURING <= 1'b0;
			STREAMING <= 1'b0;
			FILTER_EN <= 1'b0;
			FFT_EN <= 1'b0;
			DATA_DISCARD <= 1'b0;
			SAMPLE_STROBE <= 1'b0;
			RATE_SEL <= 2'h0;
		end else begin
			BUSY <= state_next inside {VCTC_IDLE, VCTC_WAIT, VCTC_STREAM};
			CAPTURING <= state_next == VCTC_CAPT;
			STREAMING <= state_next == VCTC_STREAM;
			FILTER_EN <= state_next == VCTC_PROC;
			FFT_EN <= state_next == VCTC_PROC && !offset_null_reg_reg
				&& (mode == VCTC_M_MSPEC || mode == VCTC_M_ASPEC);
			DATA_DISCARD <= esc_ev;
			SAMPLE_STROBE <= samp_tick;
			RATE_SEL <= opt_reg;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	property p_busy_low_capt;
		state_reg == VCTC_CAPT |-> !BUSY;
	endproperty
	a_busy_low_capt: assert property (p_busy_low_capt) else $error("busy high in capture");
	property p_esc_idle;
		esc_ev |=> state_reg == VCTC_IDLE ##0 BUSY;
	endproperty
	a_esc_idle: assert property (p_esc_idle) else $error("escape did not end capture");
	property p_esc_flag;
		esc_ev |=> diag_reg[`VCTC_DIAG_ESC] && DATA_DISCARD;
	endproperty
	a_esc_flag: assert property (p_esc_flag) else $error("escape flag not set");
	property p_no_pin_start;
		state_reg == VCTC_IDLE && !start_ev && !offset_null_reg_ev && !sync_rise |=> state_reg == VCTC_IDLE;
	endproperty
	a_no_pin_start: assert property (p_no_pin_start) else $error("start without trigger");
	property p_sync_gate;
		!misc_reg[`VCTC_MISC_SYNC] && state_reg == VCTC_IDLE && !cmd_ev |=> state_reg == VCTC_IDLE;
	endproperty
	a_sync_gate: assert property (p_sync_gate) else $error("pin trigger while disabled");
	property p_stream_lock;
		state_reg == VCTC_STREAM && !sync_rise && !tmo_hit |=> state_reg == VCTC_STREAM;
	endproperty
	a_stream_lock: assert property (p_stream_lock) else $error("command in stream");
	property p_tmo;
		tmo_hit && state_reg == VCTC_STREAM |=> state_reg == VCTC_IDLE ##0 BUSY;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout did not stop stream");
	property p_wait_stop;
		state_reg == VCTC_WAIT && start_ev |=> state_reg == VCTC_IDLE;
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("stop in wait ignored");
	property p_time_rate;
		state_reg == VCTC_CAPT && mode == VCTC_M_TIME && !offset_null_reg_reg |-> avg_sel == 4'h0;
	endproperty
	a_time_rate: assert property (p_time_rate) else $error("time capture decimated");
endmodule : vctc_top

// >>> tb/vctc_host_model.sv
// Host model: serial master on the link pins and driver of the sync/stop pin.
`timescale 1ns/100ps
`include "vctc_cfg.svh"
module vctc_host_model (
	// Link and sync pins.
	output logic SCLK,
	output logic CS_N,
	output logic DIN,
	output logic SYNC_STOP,
	// Ready level from the device.
	input wire logic BUSY
);
	logic ready_seen;
	// Clock idles high and stands still between frames; the idle line shows the inverse bit.
	initial begin
		SCLK = 1'b1;
		CS_N = 1'b1;
		DIN = 1'b1;
		SYNC_STOP = 1'b0;
		ready_seen = 1'b0;
	end
	// No register write until the device has first reported ready.
	always @(posedge BUSY) ready_seen = 1'b1;
	// One word, MSB first, data changed on the falling edge of a 64 ns clock.
	task automatic send_word(input logic [15:0] w);
		#7.3 CS_N = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#32 SCLK = 1'b0;
			DIN = w[i];
			#32 SCLK = 1'b1;
		end
		#32 CS_N = 1'b1;
		DIN = ~w[0];
		#32;
	endtask : send_word
	// Register write as two byte commands, the low byte first.
	task automatic write_reg(input logic [6:0] a, input logic [15:0] v);
		wait (ready_seen === 1'b1);
		send_word({1'b1, a, v[7:0]});
		send_word({1'b1, a + 7'h01, v[15:8]});
	endtask : write_reg
	// Escape repeated up to eight times, with a pause and a ready poll, until busy is high again.
	task automatic escape();
		for (int k = 0; k < 8; k++) begin
			write_reg(`VCTC_SPI_GCMD_LO, `VCTC_ESCAPE);
			#400;
			if (BUSY === 1'b1) break;
		end
	endtask : escape
	// Positive pulse on the sync/stop pin.
	task automatic pulse_sync();
		#7.3 SYNC_STOP = 1'b1;
		#200 SYNC_STOP = 1'b0;
		#200;
	endtask : pulse_sync
	// Chip select held low with the clock still, so that the stream timeout can run.
	task automatic hold_cs(input int ns);
		CS_N = 1'b0;
		#(ns) CS_N = 1'b1;
	endtask : hold_cs
endmodule : vctc_host_model

// >>> tb/vctc_top_tb.sv
// Self-checking bench of the capture controller: APB tasks, host model and scenarios.
`timescale 1ns/100ps
`include "vctc_cfg.svh"
module vctc_top_tb import vctc_pkg::*; ;
	localparam int PWUP = 20;
	localparam int TICK = 10;
	localparam int REC = 8;
	logic CLOCK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic SCLK, CS_N, DIN, SYNC_STOP, BUSY, SAMPLE_STROBE, CAPTURING, STREAMING;
	logic FILTER_EN, FFT_EN, DATA_DISCARD, er, cap_d;
	logic [15:0] OFFSET_EST;
	logic [1:0] RATE_SEL, rate_seen;
	int err_count, checks, cyc, n_str, gap, last, n_fft, n_filt, n_disc, cap_rise, cap_prev;
	int t0, s0, f0, l0, d0;
	vctc_top #(.POWERUP_CYC(PWUP), .TMO_CYC(200), .PRD_TICK_CYC(TICK), .PROC_CYC(64),
		.REC_LEN(REC)) u_dut (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .SYNC_STOP(SYNC_STOP),
		.BUSY(BUSY), .OFFSET_EST(OFFSET_EST), .SAMPLE_STROBE(SAMPLE_STROBE),
		.CAPTURING(CAPTURING), .STREAMING(STREAMING), .FILTER_EN(FILTER_EN), .FFT_EN(FFT_EN),
		.DATA_DISCARD(DATA_DISCARD), .RATE_SEL(RATE_SEL));
	vctc_host_model u_host (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .SYNC_STOP(SYNC_STOP),
		.BUSY(BUSY));
	// Clock of 4 ns.
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	// Observers of the datapath controls; the bench compares counter deltas and the last rate seen in capture.
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		cap_d <= CAPTURING;
		if (SAMPLE_STROBE === 1'b1) begin
			gap <= cyc - last;
			last <= cyc;
			n_str <= n_str + 1;
		end
		if (FFT_EN === 1'b1) n_fft <= n_fft + 1;
		if (FILTER_EN === 1'b1) n_filt <= n_filt + 1;
		if (DATA_DISCARD === 1'b1) n_disc <= n_disc + 1;
		if (CAPTURING === 1'b1) rate_seen <= RATE_SEL;
		if (CAPTURING === 1'b1 && cap_d !== 1'b1) begin
			cap_prev <= cap_rise;
			cap_rise <= cyc;
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// One APB transfer; the request stands until PREADY is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		@(posedge CLOCK);
		while (PREADY !== 1'b1 && n < 20) begin
			n++;
			@(posedge CLOCK);
		end
		rd = PRDATA;
		er = PSLVERR;
		if (n >= 20) err_count++;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	function automatic logic sig(input int w);
		case (w)
			0: return BUSY;
			1: return CAPTURING;
			default: return STREAMING;
		endcase
	endfunction : sig
	// Bounded wait for a level on busy (0), capturing (1) or streaming (2).
	task automatic wait_for(input int w, input logic lvl, input int lim);
		int n;
		n = 0;
		@(posedge CLOCK);
		while (sig(w) !== lvl && n < lim) begin
			n++;
			@(posedge CLOCK);
		end
		check("wait level", sig(w), lvl);
	endtask : wait_for
	// A hang counts as a mismatch and ends the run in the usual place.
	initial begin
		repeat (100000) @(posedge CLOCK);
		err_count++;
		tally_and_finish();
	end
	// Scenario sequence.
	initial begin
		{NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		OFFSET_EST = 16'h5A3C;
		{err_count, checks, cyc, n_str, gap, last, n_fft, n_filt, n_disc} = '0;
		{cap_rise, cap_prev, cap_d, rate_seen} = '0;
		repeat (6) @(posedge CLOCK);
		check("busy in reset", BUSY, 1'b0);
		NRST <= 1'b1;
		t0 = cyc;
		wait_for(0, 1'b1, 100);
		check("powerup time", (cyc - t0 >= PWUP) && (cyc - t0 <= PWUP + 6), 1'b1);
		for (int i = 1; i < 7; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check("reset value", rd, {16'h0000, `VCTC_RST_REG});
		end
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped", er, 1'b1);
		// Time capture ignores the enabled average and, outside autonull, never decimates.
		apb(1'b1, `VCTC_OFF_AVG, 32'h0000_0001);
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_0100);
		repeat (200) @(posedge CLOCK);
		check("idle until start", BUSY, 1'b1);
		s0 = n_str;
		f0 = n_fft;
		apb(1'b1, `VCTC_OFF_GCMD, 32'h0000_0800);
		wait_for(0, 1'b0, 20);
		wait_for(0, 1'b1, 30000);
		check("time samples", n_str - s0, REC);
		check("time rate", gap, `VCTC_BASE_DIV);
		check("time no fft", n_fft - f0, 0);
		// Manual spectrum on the sync pin, gated by the misc enable, average of two.
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_0101);
		u_host.pulse_sync();
		repeat (20) @(posedge CLOCK);
		check("sync gated", BUSY, 1'b1);
		apb(1'b1, `VCTC_OFF_MISC, 32'h0000_1000);
		s0 = n_str;
		f0 = n_fft;
		l0 = n_filt;
		u_host.pulse_sync();
		wait_for(0, 1'b0, 200);
		wait_for(0, 1'b1, 40000);
		check("spec samples", n_str - s0, REC);
		check("spec rate", gap, 2 * `VCTC_BASE_DIV);
		check("spec fft", n_fft > f0, 1'b1);
		check("spec filter", n_filt - l0, 64);
		// Serial start, an ignored command during capture with busy low, then escape.
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_0000);
		u_host.write_reg(`VCTC_SPI_GCMD_LO, 16'h0800);
		wait_for(1, 1'b1, 400);
		d0 = n_disc;
		u_host.write_reg(`VCTC_SPI_GCMD_LO, 16'h0001);
		check("ignored cmd", {BUSY, CAPTURING}, 2'b01);
		u_host.escape();
		@(posedge CLOCK);
		check("escape ready", BUSY, 1'b1);
		check("discard", n_disc - d0, 1);
		apb(1'b0, `VCTC_OFF_DIAG, 32'h0);
		check("escape flag", rd[`VCTC_DIAG_ESC], 1'b1);
		apb(1'b1, `VCTC_OFF_DIAG, 32'h0000_0010);
		apb(1'b0, `VCTC_OFF_DIAG, 32'h0);
		check("flag cleared", rd[`VCTC_DIAG_ESC], 1'b0);
		repeat (500) @(posedge CLOCK);
		check("no restart", {BUSY, CAPTURING}, 2'b10);
		// Raw stream with timeout: raw samples, serial refused, then stopped by silence.
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_8003);
		apb(1'b1, `VCTC_OFF_GCMD, 32'h0000_0800);
		wait_for(2, 1'b1, 50);
		s0 = n_str;
		f0 = n_fft;
		l0 = n_filt;
		d0 = n_disc;
		repeat (2500) @(posedge CLOCK);
		check("raw strobes", n_str - s0 >= 2, 1'b1);
		check("raw rate", gap, `VCTC_BASE_DIV);
		check("raw no fft", n_fft - f0, 0);
		check("raw no filter", n_filt - l0, 0);
		u_host.write_reg(`VCTC_SPI_GCMD_LO, `VCTC_ESCAPE);
		check("stream refuses", STREAMING, 1'b1);
		check("stream no escape", n_disc - d0, 0);
		fork
			u_host.hold_cs(1600);
			begin
				repeat (120) @(posedge CLOCK);
				check("stream held", STREAMING, 1'b1);
				repeat (260) @(posedge CLOCK);
				check("stream timeout", STREAMING, 1'b0);
			end
		join
		// Raw stream started and stopped on the sync pin.
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_0003);
		u_host.pulse_sync();
		wait_for(2, 1'b1, 200);
		u_host.pulse_sync();
		wait_for(2, 1'b0, 200);
		// Automatic spectrum: period restart, ignored write in the gap, stop by start command.
		apb(1'b1, `VCTC_OFF_AVG, 32'h0000_0000);
		apb(1'b1, `VCTC_OFF_RPRD, 32'd1100);
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_0102);
		apb(1'b1, `VCTC_OFF_GCMD, 32'h0000_0800);
		wait_for(1, 1'b1, 50);
		wait_for(0, 1'b1, 12000);
		u_host.write_reg(`VCTC_SPI_GCMD_LO, 16'h0001);
		apb(1'b0, `VCTC_OFF_STAT, 32'h0);
		check("gap state", rd[5:0], VCTC_WAIT);
		wait_for(1, 1'b1, 12000);
		@(posedge CLOCK); // Let the observer take in the capture start it just saw.
		check("period", (cap_rise - cap_prev - 1100 * TICK) inside {[-2:2]}, 1'b1);
		wait_for(0, 1'b1, 12000);
		u_host.write_reg(`VCTC_SPI_GCMD_LO, 16'h0800);
		repeat (20) @(posedge CLOCK);
		apb(1'b0, `VCTC_OFF_STAT, 32'h0);
		check("stopped", rd[5:0], VCTC_IDLE);
		// Autonull on the fourth rate option, result into the offset register.
		apb(1'b1, `VCTC_OFF_RCTL, 32'h0000_0000);
		apb(1'b1, `VCTC_OFF_GCMD, 32'h0000_0001);
		wait_for(0, 1'b0, 20);
		wait_for(0, 1'b1, 20000);
		check("null rate", rate_seen, 2'h3);
		apb(1'b0, `VCTC_OFF_NULL, 32'h0);
		check("null value", rd, 32'h0000_5A3C);
		tally_and_finish();
	end
endmodule : vctc_top_tb
